// ==== dv/csc_config_regs_props.sv ====
`timescale 1ns/1ps
module csc_config_regs_props import csc_pkg::*; #(
  parameter int SEC_CYCLES = CLK_HZ
) (
  // Watched ports
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire csc_pkg::csc_req_t regReq,
  input wire logic [7:0]        regRdata,
  input wire logic              regRvalid,
  input wire logic              upperPage,
  input wire logic              errValid,
  input wire logic [31:0]       phaseErrNs,
  input wire csc_pkg::csc_cfg_t synthCfg [NUM_SYNTH],
  input wire logic              lockFail
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr(a);
    !upperPage && regReq.wrEn && regReq.addr == a;
  endsequence
  a_page_write: assert property (regReq.wrEn && regReq.addr == ADDR_PAGE
    |=> upperPage == $past(regReq.wdata[PAGE_BIT])) else $error("page bit not written");
  a_upper_ignored: assert property (upperPage && regReq.wrEn && regReq.addr != ADDR_PAGE
    |=> $stable(synthCfg[0])) else $error("upper page write changed config");
  a_upper_zero: assert property (upperPage && regReq.rdEn && regReq.addr != ADDR_PAGE
    |=> regRvalid && regRdata == 8'h00) else $error("upper page read not zero");
  a_phase_write: assert property (s_wr(ADDR_PHASE)
    |=> synthCfg[0].phaseAdvance == $past(regReq.wdata)) else $error("phase not written");
  a_filter_write: assert property (s_wr(ADDR_FILTER)
    |=> synthCfg[0].useIntFilter == $past(regReq.wdata[FILTER_BIT])) else $error("filter bad");
  a_crit_write: assert property (s_wr(ADDR_LOCK_CRIT)
    |=> synthCfg[0].lockCrit == $past(regReq.wdata[1:0])) else $error("criterion bad");
  a_trim_msb: assert property (s_wr(ADDR_TRIM_B0)
    |=> synthCfg[0].freqTrim[31:24] == $past(regReq.wdata)) else $error("trim byte bad");
  a_copies_same: assert property (synthCfg[1] == synthCfg[0] && synthCfg[2] == synthCfg[0]
    && synthCfg[3] == synthCfg[0]) else $error("synth copies differ");
  a_bad_fails: assert property (!errValid |=> lockFail) else $error("bad sample not failed");
endmodule : csc_config_regs_props
bind csc_config_regs csc_config_regs_props #(.SEC_CYCLES(SEC_CYCLES)) u_props (
  .core_clk(core_clk), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
  .regRvalid(regRvalid), .upperPage(upperPage), .errValid(errValid),
  .phaseErrNs(phaseErrNs), .synthCfg(synthCfg), .lockFail(lockFail));

// ==== dv/csc_host_model.sv ====
`timescale 1ns/1ps
module csc_host_model (
  // Bus side
  input  wire logic        core_clk,
  input  wire logic [7:0]  regRdata,
  input  wire logic        regRvalid,
  output csc_pkg::csc_req_t regReq
);
  import csc_pkg::*;
  initial regReq = '0;
  // Released lines show the inverse so a stale value can never match
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk) regReq <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk) regReq <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(posedge core_clk) regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk) regReq <= '{1'b0, 1'b0, ~a, 8'hFF};
    @(negedge core_clk);
    v = regRvalid;
    d = regRdata;
  endtask : rd
  // Upper half is only reachable after the page bit is set
  task automatic page(input logic p);
    wr(ADDR_PAGE, {7'h00, p});
  endtask : page
endmodule : csc_host_model

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
  import csc_pkg::*;
  localparam int SEC = 10;
  logic core_clk, rst_b, errValid, regRvalid, upperPage, lockFail, v;
  logic [31:0] phaseErrNs;
  logic [7:0]  regRdata, d;
  csc_req_t    regReq;
  csc_cfg_t    synthCfg [NUM_SYNTH];
  int miscompares = 0;
  int totalChecks = 0;
  int cycles = 0;
  csc_config_regs #(.SEC_CYCLES(SEC)) u_csc_config_regs (.core_clk(core_clk), .rst_b(rst_b),
    .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid), .upperPage(upperPage),
    .errValid(errValid), .phaseErrNs(phaseErrNs), .synthCfg(synthCfg), .lockFail(lockFail));
  csc_host_model u_csc_host_model (.core_clk(core_clk), .regRdata(regRdata),
    .regRvalid(regRvalid), .regReq(regReq));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    u_csc_host_model.rd(a, d, v);
    chk("regRvalid", 1, v);
    chk("regRdata", e, d);
  endtask : rdchk
  task automatic cfgchk(input logic [31:0] t, input logic f, input logic [7:0] p);
    // A write lands on the edge that returns from wr; look once it has settled
    @(negedge core_clk);
    for (int i = 0; i < NUM_SYNTH; i++) begin
      chk("freqTrim", t, synthCfg[i].freqTrim);
      chk("useIntFilter", f, synthCfg[i].useIntFilter);
      chk("phaseAdvance", p, synthCfg[i].phaseAdvance);
    end
  endtask : cfgchk
  task automatic t_reset;
    logic [31:0] t = 32'h046A_AAAB;
    rdchk(ADDR_LOCK_CRIT, 8'hAA);
    for (int i = 0; i < 4; i++) rdchk(ADDR_TRIM_B0 + 7'(i), t[31-8*i -: 8]);
    rdchk(ADDR_FILTER, 8'h00);
    rdchk(ADDR_PHASE, 8'h00);
    rdchk(ADDR_PAGE, 8'h00);
    cfgchk(t, 1'b0, 8'h00);
    chk("lockFail", 1, lockFail);
  endtask : t_reset
  task automatic t_cfg;
    logic [31:0] t = 32'hFAFA_FAFB;
    for (int i = 0; i < 4; i++) u_csc_host_model.wr(ADDR_TRIM_B0 + 7'(i), 8'h00);
    cfgchk(32'h0000_0000, 1'b0, 8'h00);
    // Negative trim, about two percent, stays inside the allowed span
    for (int i = 0; i < 4; i++) u_csc_host_model.wr(ADDR_TRIM_B0 + 7'(i), t[31-8*i -: 8]);
    u_csc_host_model.wr(ADDR_FILTER, 8'h01);
    u_csc_host_model.wr(ADDR_PHASE, 8'hFF);
    cfgchk(t, 1'b1, 8'hFF);
    rdchk(ADDR_TRIM_B3, 8'hFB);
    u_csc_host_model.wr(ADDR_FILTER, 8'hFE);
    cfgchk(t, 1'b0, 8'hFF);
  endtask : t_cfg
  task automatic t_page;
    u_csc_host_model.page(1'b1);
    @(negedge core_clk);
    chk("upperPage", 1, upperPage);
    u_csc_host_model.wr(ADDR_PHASE, 8'h11);
    rdchk(ADDR_PHASE, 8'h00);
    rdchk(ADDR_PAGE, 8'h01);
    chk("phaseAdvance", 8'hFF, synthCfg[0].phaseAdvance);
    u_csc_host_model.page(1'b0);
    rdchk(ADDR_PHASE, 8'hFF);
    rdchk(7'h10, 8'h00);
  endtask : t_page
  task automatic t_lock;
    int lim [4] = '{36000, 1000, 10000, 10000};
    int win [4] = '{10, 1, 1, 10};
    for (int c = 0; c < 4; c++) begin
      u_csc_host_model.wr(ADDR_LOCK_CRIT, 8'(c));
      errValid <= 1'b1;
      phaseErrNs <= 32'(lim[c] - 1);
      repeat (win[c] * SEC - 1) @(posedge core_clk);
      @(negedge core_clk);
      chk("lockCrit", c, synthCfg[0].lockCrit);
      chk("lockFail", 1, lockFail);
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      chk("lockFail", 0, lockFail);
      @(posedge core_clk) phaseErrNs <= 32'(lim[c]);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk("lockFail", 1, lockFail);
    end
  endtask : t_lock
  task automatic final_report;
    if (miscompares == 0 && totalChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    rst_b = 1'b0;
    errValid = 1'b0;
    phaseErrNs = 32'h0000_0000;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_cfg();
    t_page();
    t_lock();
    final_report();
  end
endmodule : tb

// ==== include/csc_pkg.sv ====
package csc_pkg;

  // 7-bit port address offsets (page 0 unless noted)
  localparam logic [6:0] ADDR_LOCK_CRIT  = 7'h72;
  localparam logic [6:0] ADDR_TRIM_B0    = 7'h73;
  localparam logic [6:0] ADDR_TRIM_B3    = 7'h76;
  localparam logic [6:0] ADDR_FILTER     = 7'h77;
  localparam logic [6:0] ADDR_PHASE      = 7'h78;
  localparam logic [6:0] ADDR_PAGE       = 7'h7F;

  // Reset values
  localparam logic [7:0]  RST_LOCK_CRIT  = 8'hAA;
  localparam logic [31:0] RST_TRIM       = 32'h046A_AAAB;
  localparam logic [7:0]  RST_FILTER     = 8'h00;
  localparam logic [7:0]  RST_PHASE      = 8'h00;
  localparam logic [7:0]  RST_PAGE       = 8'h00;

  // Field positions
  localparam int LOCK_CRIT_MSB = 1;
  localparam int FILTER_BIT    = 0;
  localparam int PAGE_BIT      = 0;

  localparam int NUM_SYNTH = 4;

  // Clock and lock-criterion timing
  localparam int CLK_HZ     = 20_000_000;
  localparam int CLK_NS     = 50;
  localparam int PHASE_STEPS = 256;

  typedef enum logic [1:0] {
    LOCK_36US_10S = 2'b00,
    LOCK_1US_1S   = 2'b01,
    LOCK_10US_1S  = 2'b10,
    LOCK_10US_10S = 2'b11
  } csc_crit_t;

  // Phase error limits in nanoseconds
  localparam logic [31:0] LIM_36US_NS = 32'h0000_8CA0;
  localparam logic [31:0] LIM_10US_NS = 32'h0000_2710;
  localparam logic [31:0] LIM_1US_NS  = 32'h0000_03E8;
  // Observation windows in seconds
  localparam int WIN_LONG_S  = 10;
  localparam int WIN_SHORT_S = 1;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [6:0] addr;
    logic [7:0] wdata;
  } csc_req_t;

  typedef struct packed {
    csc_crit_t   lockCrit;
    logic [31:0] freqTrim;
    logic        useIntFilter;
    logic [7:0]  phaseAdvance;
  } csc_cfg_t;

endpackage : csc_pkg

// ==== rtl/csc_config_regs.sv ====
`timescale 1ns/1ps
module csc_config_regs #(
  parameter int SEC_CYCLES = csc_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  // Register port from the serial interface logic
  input  wire csc_pkg::csc_req_t  regReq,
  output logic [7:0]              regRdata,
  output logic                    regRvalid,
  output logic                    upperPage,
  // Phase error from the digital PLL
  input  wire logic               errValid,
  input  wire logic [31:0]        phaseErrNs,
  // Configuration to the synthesizers
  output csc_pkg::csc_cfg_t       synthCfg [csc_pkg::NUM_SYNTH],
  output logic                    lockFail
);
  import csc_pkg::*;

  logic       rstMeta_ff;
  logic       rstSyncB;
  logic       rstSync_ff;

  // Reset released through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end
  assign rstSyncB = rstSync_ff;

  logic [7:0]  lockCrit_ff,  nxt_lockCrit;
  logic [31:0] freqTrim_ff,  nxt_freqTrim;
  logic [7:0]  filterSel_ff, nxt_filterSel;
  logic [7:0]  phaseAdv_ff,  nxt_phaseAdv;
  logic [7:0]  page_ff,      nxt_page;
  logic [7:0]  rdata_ff,     nxt_rdata;
  logic        rvalid_ff,    nxt_rvalid;
  logic        pageHi;
  logic        isPageReg;
  logic        onPage0;
  logic [1:0]  trimByte;

  assign pageHi    = page_ff[PAGE_BIT];
  // Page register sits outside the paged space so the host can always return
  assign isPageReg = (regReq.addr == ADDR_PAGE);
  // Upper page locations live in other blocks; here only page 0 decodes
  assign onPage0   = !pageHi;
  assign trimByte  = 2'(regReq.addr - ADDR_TRIM_B0);

  always_comb begin
    nxt_lockCrit  = lockCrit_ff;
    nxt_freqTrim  = freqTrim_ff;
    nxt_filterSel = filterSel_ff;
    nxt_phaseAdv  = phaseAdv_ff;
    nxt_page      = page_ff;
    nxt_rdata     = rdata_ff;
    nxt_rvalid    = 1'b0;
    if (regReq.wrEn) begin
      if (isPageReg) begin
        nxt_page = regReq.wdata;
      end else if (onPage0) begin
        case (regReq.addr)
          ADDR_LOCK_CRIT: nxt_lockCrit  = regReq.wdata;
          ADDR_FILTER:    nxt_filterSel = regReq.wdata;
          ADDR_PHASE:     nxt_phaseAdv  = regReq.wdata;
          default: begin
            if (regReq.addr >= ADDR_TRIM_B0 && regReq.addr <= ADDR_TRIM_B3) begin
              // Byte 0x73 is the most significant byte of the trim word
              case (trimByte)
                2'd0:    nxt_freqTrim[31:24] = regReq.wdata;
                2'd1:    nxt_freqTrim[23:16] = regReq.wdata;
                2'd2:    nxt_freqTrim[15:8]  = regReq.wdata;
                default: nxt_freqTrim[7:0]   = regReq.wdata;
              endcase
            end
          end
        endcase
      end
    end
    if (regReq.rdEn) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = 8'h00;
      if (isPageReg) begin
        nxt_rdata = page_ff;
      end else if (onPage0) begin
        case (regReq.addr)
          ADDR_LOCK_CRIT: nxt_rdata = lockCrit_ff;
          ADDR_FILTER:    nxt_rdata = filterSel_ff;
          ADDR_PHASE:     nxt_rdata = phaseAdv_ff;
          default: begin
            if (regReq.addr >= ADDR_TRIM_B0 && regReq.addr <= ADDR_TRIM_B3) begin
              case (trimByte)
                2'd0:    nxt_rdata = freqTrim_ff[31:24];
                2'd1:    nxt_rdata = freqTrim_ff[23:16];
                2'd2:    nxt_rdata = freqTrim_ff[15:8];
                default: nxt_rdata = freqTrim_ff[7:0];
              endcase
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      lockCrit_ff  <= RST_LOCK_CRIT;
      freqTrim_ff  <= RST_TRIM;
      filterSel_ff <= RST_FILTER;
      phaseAdv_ff  <= RST_PHASE;
      page_ff      <= RST_PAGE;
      rdata_ff     <= 8'h00;
      rvalid_ff    <= 1'b0;
    end else begin
      lockCrit_ff  <= nxt_lockCrit;
      freqTrim_ff  <= nxt_freqTrim;
      filterSel_ff <= nxt_filterSel;
      phaseAdv_ff  <= nxt_phaseAdv;
      page_ff      <= nxt_page;
      rdata_ff     <= nxt_rdata;
      rvalid_ff    <= nxt_rvalid;
    end
  end

  assign regRdata  = rdata_ff;
  assign regRvalid = rvalid_ff;
  assign upperPage = pageHi;

  // Trim range is the host's duty; no clamping so NCO sweeps stay exact
  genvar s;
  generate
    for (s = 0; s < NUM_SYNTH; s++) begin : g_synth
      // Every synthesizer gets the same trim and phase word
      assign synthCfg[s].lockCrit     = csc_crit_t'(lockCrit_ff[LOCK_CRIT_MSB:0]);
      assign synthCfg[s].freqTrim     = freqTrim_ff;
      assign synthCfg[s].useIntFilter = filterSel_ff[FILTER_BIT];
      assign synthCfg[s].phaseAdvance = phaseAdv_ff;
    end
  endgenerate

  csc_lock_eval #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_lock_eval (
    .clk        (core_clk),
    .rstSyncB   (rstSyncB),
    .crit       (csc_crit_t'(lockCrit_ff[LOCK_CRIT_MSB:0])),
    .errValid   (errValid),
    .phaseErrNs (phaseErrNs),
    .lockFail   (lockFail)
  );

endmodule : csc_config_regs

// ==== rtl/csc_lock_eval.sv ====
`timescale 1ns/1ps
module csc_lock_eval #(
  parameter int SEC_CYCLES = 20_000_000
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rstSyncB,
  // Criterion and phase error
  input  wire csc_pkg::csc_crit_t  crit,
  input  wire logic                errValid,
  input  wire logic [31:0]         phaseErrNs,
  // Result
  output logic                     lockFail
);
  import csc_pkg::*;

  logic [31:0] limitNs;
  logic [3:0]  winSec;
  logic        errOk;
  logic [31:0] cycCnt_ff, nxt_cycCnt;
  logic [3:0]  secCnt_ff, nxt_secCnt;
  logic        lockFail_ff, nxt_lockFail;
  csc_crit_t   critSeen_ff, nxt_critSeen;

  always_comb begin
    case (crit)
      LOCK_36US_10S: begin limitNs = LIM_36US_NS; winSec = 4'(WIN_LONG_S);  end
      LOCK_1US_1S:   begin limitNs = LIM_1US_NS;  winSec = 4'(WIN_SHORT_S); end
      LOCK_10US_1S:  begin limitNs = LIM_10US_NS; winSec = 4'(WIN_SHORT_S); end
      LOCK_10US_10S: begin limitNs = LIM_10US_NS; winSec = 4'(WIN_LONG_S);  end
      default:       begin limitNs = LIM_36US_NS; winSec = 4'(WIN_LONG_S);  end
    endcase
  end

  // Error magnitude is unsigned; an invalid sample counts as a violation
  assign errOk = errValid && (phaseErrNs < limitNs);

  always_comb begin
    nxt_cycCnt   = cycCnt_ff;
    nxt_secCnt   = secCnt_ff;
    nxt_lockFail = lockFail_ff;
    nxt_critSeen = crit;
    // Restart the window on any violation or a change of criterion
    if (!errOk || (crit != critSeen_ff)) begin
      nxt_cycCnt   = '0;
      nxt_secCnt   = '0;
      nxt_lockFail = 1'b1;
    end else if (secCnt_ff >= winSec) begin
      nxt_lockFail = 1'b0;
    end else if (cycCnt_ff == 32'(SEC_CYCLES - 1)) begin
      nxt_cycCnt = '0;
      nxt_secCnt = secCnt_ff + 4'h1;
    end else begin
      nxt_cycCnt = cycCnt_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      cycCnt_ff   <= '0;
      secCnt_ff   <= '0;
      lockFail_ff <= 1'b1;
      critSeen_ff <= LOCK_36US_10S;
    end else begin
      cycCnt_ff   <= nxt_cycCnt;
      secCnt_ff   <= nxt_secCnt;
      lockFail_ff <= nxt_lockFail;
      critSeen_ff <= nxt_critSeen;
    end
  end

  assign lockFail = lockFail_ff;

endmodule : csc_lock_eval
